// ### design/aih_pkg.sv
// package of constants and types shared by both ends of the injected result handshake
package aih_pkg;
	localparam int RES_W = 10; // result width
	localparam int CONV_CYCLES = 20; // conversion time in clock cycles
	localparam logic [RES_W-1:0] RES_RESET = 10'h000; // result reset value
	localparam logic WFR_RESET = 1'b1; // wait-for-read history resets high
	typedef enum logic [1:0] {AIH_IDLE, AIH_CONV, AIH_DONE, AIH_STALL} aih_state_e;
	typedef enum logic [1:0] {AIH_RD_IDLE, AIH_RD_FIRST, AIH_RD_SECOND} aih_rd_e;
endpackage

// ### design/aih_if.sv
// interface joining the converter end and the result reader end
`timescale 1ns/1ps
interface aih_if #(parameter int RES_W = 10) (
	input logic sys_clk,
	input logic rst
);
	logic [RES_W-1:0] injected_result_register; // injected result value
	logic result_valid; // unread result present
	logic stalled; // converter stalled
	logic rd_strobe; // one-cycle read of the result register
	modport dev (
		input sys_clk,
		input rst,
		output injected_result_register,
		output result_valid,
		output stalled,
		input rd_strobe
	);
	modport rdr (
		input sys_clk,
		input rst,
		input injected_result_register,
		input result_valid,
		input stalled,
		output rd_strobe
	);
endinterface

// ### design/aih_converter.sv
// converter end: injected conversion sequencer with wait-for-read stall
`timescale 1ns/1ps
//
// The converter runs one injected conversion per trigger. With wait-for-read
// enabled, a finished result must be read before the next injection; a
// hardware trigger that meets an unread result parks the sequencer in a
// stall state, while a software trigger that meets one is simply dropped.
// Leaving the stall takes either a pair of reads from the far end or a
// low-then-high pulse on the wait-for-read input.
// Hazards worth knowing:
// - the read parity restarts at every new result and on stall entry, so a
//   stray single read before a stall never counts toward the release pair;
// - a result that completes in the same cycle as a read stays unread, so the
//   reader sees no new rising edge of result_valid and never marks the newest value pending;
// - the wait-for-read history resets high, so the input must be seen low for
//   at least one edge before a high level counts as a release.
module aih_converter import aih_pkg::*; #(
	parameter int RES_W_P = RES_W,
	parameter int CONV_P = CONV_CYCLES
) (
	aih_if.dev link,
	input wire logic capture_channel_trigger,
	input wire logic sw_trigger,
	input wire logic [RES_W_P-1:0] analog_sample,
	input wire logic wait_for_read,
	output logic conv_busy,
	output logic stall_flag
);
	// elaboration checks: the link carries the package width, and the 16-bit
	// down-counter can only time conversions of 1 to 65535 cycles
	initial begin
		if (RES_W_P != RES_W) begin
			$error("aih_converter: result width must match the link");
		end
		if (CONV_P < 1 || CONV_P > 65535) begin
			$error("aih_converter: conversion length out of range");
		end
	end

	// ----------------------------------------
	// state and counters
	// ----------------------------------------
	aih_state_e state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [RES_W_P-1:0] res_q, res_d;
	logic unread_q, unread_d;
	logic reads_q, reads_d; // one read seen since stall or result
	logic wfr_q;
	logic stall_q;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// only the hardware trigger can stall the sequencer
	wire logic hw_req = capture_channel_trigger;
	wire logic any_req = hw_req | sw_trigger;
	// release by a low-then-high pulse on the mode input
	wire logic wfr_rise = wait_for_read & ~wfr_q;
	// the second read of a pair; parity restarts at each result and at stall entry
	wire logic second_read = link.rd_strobe & reads_q;
	// a read consumes the result everywhere except in the stall state
	wire logic read_clears = link.rd_strobe & (state_q != AIH_STALL);
	wire logic conv_end = (state_q == AIH_CONV) && (cnt_q == 16'h0000);
	// an injection that would overwrite an unread result
	wire logic stall_req = hw_req & unread_q & wait_for_read;
	// a software trigger meeting an unread result is dropped, not stalled
	wire logic sw_blocked = unread_q & wait_for_read & ~link.rd_strobe;
	// register inputs of the flag outputs
	wire logic stall_d = (state_d == AIH_STALL);
	wire logic busy_d = (state_d == AIH_CONV);

	// next state logic
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		res_d = res_q;
		unread_d = unread_q;
		reads_d = reads_q;
		// a read flips the pair parity; a result, a stall entry or a stall release restarts it below
		if (link.rd_strobe) begin
			reads_d = ~reads_q;
		end
		// a read consumes the result; a result finishing this cycle overrides below
		if (read_clears) begin
			unread_d = 1'b0;
		end
		unique case (state_q)
			AIH_IDLE, AIH_DONE: begin
				// a stall takes priority over starting a conversion
				if (stall_req) begin
					state_d = AIH_STALL;
					reads_d = 1'b0;
				end else if (any_req && !sw_blocked) begin
					state_d = AIH_CONV;
					cnt_d = 16'(CONV_P - 1);
				end
			end
			AIH_CONV: begin
				if (cnt_q != 16'h0000) begin
					cnt_d = cnt_q - 16'h0001;
				end
				// the last counted cycle latches the sample
				if (conv_end) begin
					res_d = analog_sample;
					unread_d = 1'b1; // set wins over any read this cycle
					reads_d = 1'b0;
					state_d = AIH_DONE;
				end
			end
			AIH_STALL: begin
				// triggers ignored and result held here
				if (second_read || wfr_rise) begin
					state_d = AIH_IDLE;
					unread_d = 1'b0;
					reads_d = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// sequencer state
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			state_q <= AIH_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// conversion down-counter
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// result register, frozen while stalled
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			res_q <= RES_RESET;
		end else begin
			res_q <= res_d;
		end
	end

	// unread flag; a finishing result wins over a read in the same cycle
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			unread_q <= 1'b0;
		end else begin
			unread_q <= unread_d;
		end
	end

	// read pair parity
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			reads_q <= 1'b0;
		end else begin
			reads_q <= reads_d;
		end
	end

	// wait-for-read history; resets high so a release needs the input low first
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			wfr_q <= WFR_RESET;
		end else begin
			wfr_q <= wait_for_read;
		end
	end

	// stall flag, registered so the link sees no decode glitches
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= stall_d;
		end
	end

	// busy output, high while a conversion runs
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			conv_busy <= 1'b0;
		end else begin
			conv_busy <= busy_d;
		end
	end

	// ----------------------------------------
	// outputs to the link, all straight from registers
	// ----------------------------------------
	assign link.injected_result_register = res_q;
	assign link.result_valid = unread_q;
	assign link.stalled = stall_q;
	assign stall_flag = stall_q;
endmodule

// ### design/aih_reader.sv
// reader end: fetches injected results by double read or single transfer-unit read
`timescale 1ns/1ps
module aih_reader import aih_pkg::*; #(
	parameter int RES_W_P = RES_W
) (
	aih_if.rdr link,
	input wire logic transfer_enable,
	input wire logic single_read_mode,
	output logic [RES_W_P-1:0] fetched_result,
	output logic fetched_pulse
);
	initial begin
		if (RES_W_P != RES_W) begin
			$error("aih_reader: unsupported width");
		end
	end

	// ----------------------------------------
	// read sequencer
	// ----------------------------------------
	aih_rd_e st_q, st_d;
	logic rd_q;
	logic valid_q;
	logic pend_q;

	wire logic new_result = link.result_valid & ~valid_q;
	// a result stays pending until fetched or withdrawn by a stall release
	wire logic pend_d = new_result | (pend_q & link.result_valid & (st_q != AIH_RD_FIRST));
	// the transfer unit serves a pending result once and re-reads a stall only outside single read mode
	wire logic start_rd = pend_q | new_result | (link.stalled & ~single_read_mode);
	// a blocked transfer unit leaves results unread
	wire logic may_read = transfer_enable;

	// next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			AIH_RD_IDLE: begin
				if (start_rd && may_read) begin
					st_d = AIH_RD_FIRST;
				end
			end
			AIH_RD_FIRST: begin
				st_d = single_read_mode ? AIH_RD_IDLE : AIH_RD_SECOND;
			end
			AIH_RD_SECOND: begin
				st_d = AIH_RD_IDLE;
			end
		endcase
	end

	// registers
	always_ff @(posedge link.sys_clk) begin
		if (link.rst) begin
			st_q <= AIH_RD_IDLE;
			rd_q <= 1'b0;
			valid_q <= 1'b0;
			pend_q <= 1'b0;
			fetched_result <= RES_RESET;
			fetched_pulse <= 1'b0;
		end else begin
			st_q <= st_d;
			rd_q <= (st_d != AIH_RD_IDLE);
			valid_q <= link.result_valid;
			pend_q <= pend_d;
			fetched_pulse <= (st_q == AIH_RD_FIRST);
			if (st_q == AIH_RD_FIRST) begin
				fetched_result <= link.injected_result_register;
			end
		end
	end

	assign link.rd_strobe = rd_q;
endmodule

// ### tb/aih_assertions.sv
// checker of the injected result handshake on the link between both ends
`timescale 1ns/1ps
module aih_assertions #(parameter int RES_W = 10) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [RES_W-1:0] injected_result_register,
	input wire logic result_valid,
	input wire logic stalled,
	input wire logic rd_strobe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_stall_holds_result: assert property (stalled ##1 stalled |-> $stable(injected_result_register))
		else $error("result moved while stalled");
	a_stall_no_result: assert property (stalled ##1 stalled |-> !$rose(result_valid))
		else $error("new result while stalled");
	a_stall_needs_unread: assert property ($rose(stalled) |-> $past(result_valid))
		else $error("stall without unread result");
	a_valid_stands: assert property (result_valid && !rd_strobe && !stalled |=> result_valid)
		else $error("unread result dropped");
	a_two_reads_free: assert property (stalled && rd_strobe ##1 rd_strobe |-> ##[1:2] !stalled)
		else $error("double read left converter stalled");
	a_read_clears: assert property (result_valid && rd_strobe && !stalled |=> !result_valid)
		else $error("read did not clear result");
	a_read_pair_max: assert property (rd_strobe ##1 rd_strobe |=> !rd_strobe)
		else $error("more than two reads in a row");
	a_read_has_cause: assert property ($rose(rd_strobe) |-> $past(result_valid))
		else $error("read without a result");
endmodule

// ### tb/adc_injected_result_handshake_bench.sv
// self-checking bench for both ends of the injected result handshake
`timescale 1ns/1ps
module adc_injected_result_handshake_bench import aih_pkg::*;;
	logic sys_clk = 0, rst = 1, hw = 0, sw = 0, wfr = 1, ten = 1, srm = 0, busy, sflag, fpulse;
	logic [RES_W-1:0] smp = 0, fres;
	logic [RES_W-1:0] exp_q[$];
	logic [7:0] lfsr_q = 8'h52;
	int miscompares = 0, tests_run = 0, cyc = 0;
	aih_if #(.RES_W(RES_W)) i_aih_if (.sys_clk(sys_clk), .rst(rst));
	aih_converter i_aih_converter (.link(i_aih_if), .capture_channel_trigger(hw), .sw_trigger(sw),
		.analog_sample(smp), .wait_for_read(wfr), .conv_busy(busy), .stall_flag(sflag));
	aih_reader i_aih_reader (.link(i_aih_if), .transfer_enable(ten), .single_read_mode(srm),
		.fetched_result(fres), .fetched_pulse(fpulse));
	aih_assertions #(.RES_W(RES_W)) i_aih_assertions (.sys_clk(sys_clk), .rst(rst), .rd_strobe(i_aih_if.rd_strobe),
		.injected_result_register(i_aih_if.injected_result_register),
		.result_valid(i_aih_if.result_valid), .stalled(i_aih_if.stalled));
	always #20 sys_clk = ~sys_clk;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [RES_W-1:0] e, input logic [RES_W-1:0] s);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// next value of the stimulus shift register
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// one trigger pulse with a fresh sample; mdl says the model expects a result
	task automatic inject(input logic use_hw, input bit mdl);
		lfsr_q = lfsr_next(lfsr_q);
		smp <= {lfsr_q[1:0], lfsr_q};
		hw <= use_hw;
		sw <= !use_hw;
		if (mdl)
			exp_q.push_back({lfsr_q[1:0], lfsr_q});
		@(posedge sys_clk);
		hw <= 1'b0;
		sw <= 1'b0;
		@(posedge sys_clk);
		chk("conv_busy", RES_W'(mdl), RES_W'(busy));
		repeat (CONV_CYCLES + 4) @(posedge sys_clk);
		chk("conv_busy", 0, RES_W'(busy));
	endtask
	// timeout and comparison of every fetched result with the model
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			miscompares++;
			wrap_up();
		end
		if (fpulse === 1'b1)
			chk("fetched_result", exp_q.size() > 0 ? exp_q.pop_front() : 'x, fres);
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		inject(1, 1);
		inject(0, 1);
		ten <= 1'b0;
		inject(0, 1);
		inject(0, 0);
		chk("stall_flag", 0, RES_W'(sflag));
		inject(1, 0);
		chk("stall_flag", 1, RES_W'(sflag));
		inject(1, 0);
		chk("stall_flag", 1, RES_W'(sflag));
		srm <= 1'b1;
		ten <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ten <= 1'b0;
		chk("stall_flag", 1, RES_W'(sflag));
		wfr <= 1'b0;
		@(posedge sys_clk);
		wfr <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("stall_flag", 0, RES_W'(sflag));
		srm <= 1'b0;
		ten <= 1'b1;
		repeat (4) @(posedge sys_clk);
		exp_q.delete();
		ten <= 1'b0;
		inject(1, 1);
		inject(1, 0);
		ten <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chk("stall_flag", 0, RES_W'(sflag));
		inject(1, 1);
		chk("results_left", 0, RES_W'(exp_q.size()));
		wrap_up();
	end
endmodule
